// >>> core/pes_map.svh
// What this block does
// - Event 77H counts bus snoop responses
// - Snoop count filtered by type and agent
// - Bus events count whole core, ignore thread
// - Event 7AH counts clean snoop pin cycles
// - Event 7BH counts modified snoop pin cycles
// - Event 7DH counts cycles bus queue idle
// - Event 7EH counts snoop stall assertions
// - No snooped transaction starts during stall
// - Event 7FH counts cycles with I/O waiting
// - Event 80H/03H counts every instruction fetch of the owner thread, or of both threads when all_threads_qualifier is set
// - Event 80H/02H counts fetch misses, uncacheable too
// - One fetch miss counts exactly once
// - Event 82H/04H counts translation buffer flushes
// - Event 82H/02H counts translation buffer misses
`ifndef PES_MAP_SVH
`define PES_MAP_SVH

`define PES_CNT_W 40
`define PES_CNT_RST 40'h00_0000_0000
`define PES_CNT_ONE 40'h00_0000_0001

`define PES_EV_SNOOP_RESP 8'h77
`define PES_EV_CLEAN_DRV 8'h7A
`define PES_EV_MOD_DRV 8'h7B
`define PES_EV_QUEUE_IDLE 8'h7D
`define PES_EV_STALL 8'h7E
`define PES_EV_IO_WAIT 8'h7F
`define PES_EV_FETCH 8'h80
`define PES_EV_TLB 8'h82

`define PES_UM_FETCH_ALL 8'h03
`define PES_UM_FETCH_MISS 8'h02
`define PES_UM_TLB_FLUSH 8'h04
`define PES_UM_TLB_MISS 8'h02

// Snoop response unit mask fields
`define PES_UM_TYPE_LSB 0
`define PES_UM_TYPE_W 3
`define PES_UM_AGENT_LSB 4
`define PES_UM_AGENT_W 2

// Snoop response kinds on snoop_resp_kind
`define PES_RESP_CLEAN 2'h0
`define PES_RESP_HIT 2'h1
`define PES_RESP_MODIFIED_LINE_SNOOP_PIN 2'h2

`endif

// >>> core/pes_pkg.sv
`include "pes_map.svh"

package pes_pkg;

    typedef enum logic [3:0] {
        PES_SRC_NONE,
        PES_SRC_SNOOP_RESP,
        PES_SRC_CLEAN_DRV,
        PES_SRC_MOD_DRV,
        PES_SRC_QUEUE_IDLE,
        PES_SRC_STALL,
        PES_SRC_IO_WAIT,
        PES_SRC_FETCH,
        PES_SRC_FETCH_MISS,
        PES_SRC_TLB_FLUSH,
        PES_SRC_TLB_MISS
    } pes_src_type;

    typedef struct packed {
        logic [`PES_CNT_W-1:0] count;
        logic stall_prev;
        logic miss_prev;
    } pes_state_type;

    function automatic logic pes_rise(input logic now, input logic prev);
        return now & ~prev;
    endfunction : pes_rise

endpackage : pes_pkg

// >>> core/pes_sel_if.sv
`timescale 1ns/1ns

interface pes_sel_if;
    import pes_pkg::*;
    logic [7:0] event_num;
    logic [7:0] unit_mask;
    pes_src_type src;
    modport decoder (input event_num, input unit_mask, output src);
    modport counter (output event_num, output unit_mask, input src);
endinterface : pes_sel_if

// >>> core/pes_event_decode.sv
`timescale 1ns/1ns
`include "pes_map.svh"

module pes_event_decode
    import pes_pkg::*;
(
    pes_sel_if.decoder sel
);

    logic [`PES_UM_TYPE_W-1:0] type_bits;
    logic [`PES_UM_AGENT_W-1:0] agent_bits;

    assign type_bits = sel.unit_mask[`PES_UM_TYPE_LSB +: `PES_UM_TYPE_W];
    assign agent_bits = sel.unit_mask[`PES_UM_AGENT_LSB +: `PES_UM_AGENT_W];

    // Bus events other than 77H take their qualifiers from elsewhere; any mask accepted
    always_comb begin
        sel.src = PES_SRC_NONE;
        if (sel.event_num == `PES_EV_SNOOP_RESP) begin
            if (|type_bits && |agent_bits) begin
                sel.src = PES_SRC_SNOOP_RESP;
            end
        end else if (sel.event_num == `PES_EV_CLEAN_DRV) begin
            sel.src = PES_SRC_CLEAN_DRV;
        end else if (sel.event_num == `PES_EV_MOD_DRV) begin
            sel.src = PES_SRC_MOD_DRV;
        end else if (sel.event_num == `PES_EV_QUEUE_IDLE) begin
            sel.src = PES_SRC_QUEUE_IDLE;
        end else if (sel.event_num == `PES_EV_STALL) begin
            sel.src = PES_SRC_STALL;
        end else if (sel.event_num == `PES_EV_IO_WAIT) begin
            sel.src = PES_SRC_IO_WAIT;
        end else if (sel.event_num == `PES_EV_FETCH) begin
            if (sel.unit_mask == `PES_UM_FETCH_ALL) begin
                sel.src = PES_SRC_FETCH;
            end else if (sel.unit_mask == `PES_UM_FETCH_MISS) begin
                sel.src = PES_SRC_FETCH_MISS;
            end
        end else if (sel.event_num == `PES_EV_TLB) begin
            if (sel.unit_mask == `PES_UM_TLB_FLUSH) begin
                sel.src = PES_SRC_TLB_FLUSH;
            end else if (sel.unit_mask == `PES_UM_TLB_MISS) begin
                sel.src = PES_SRC_TLB_MISS;
            end
        end
    end

endmodule : pes_event_decode

// >>> core/pes_event_counter.sv
`timescale 1ns/1ns
`include "pes_map.svh"

module pes_event_counter
    import pes_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Selection
    input wire logic [7:0] event_num,
    input wire logic [7:0] unit_mask,
    input wire logic all_threads_qualifier,
    input wire logic owner_thread,
    input wire logic count_clear,
    // Bus unit
    input wire logic bus_cycle_strobe,
    input wire logic snoop_resp_valid,
    input wire logic [1:0] snoop_resp_kind,
    input wire logic snoop_resp_other_agent,
    input wire logic clean_snoop_pin_drive,
    input wire logic modified_line_snoop_pin_drive,
    input wire logic bus_queue_pending,
    input wire logic snoop_stall,
    input wire logic io_req_waiting,
    // Bus request gate
    input wire logic bus_req_valid,
    input wire logic bus_req_needs_snoop,
    output logic bus_req_grant,
    // Fetch unit
    input wire logic fetch_valid,
    input wire logic fetch_thread,
    input wire logic fetch_miss_pending,
    input wire logic tlb_flush,
    input wire logic tlb_miss,
    // Result
    output logic [`PES_CNT_W-1:0] count
);

    pes_sel_if sel_if ();

    pes_state_type state_r;
    pes_state_type state_nxt;

    logic type_match;
    logic agent_match;
    logic snoop_hit;
    logic thread_ok;
    logic inc;

    assign sel_if.event_num = event_num;
    assign sel_if.unit_mask = unit_mask;

    pes_event_decode u_decode (
        .sel(sel_if.decoder)
    );

    always_comb begin
        type_match = 1'b0;
        if (snoop_resp_kind == `PES_RESP_CLEAN) begin
            type_match = unit_mask[`PES_UM_TYPE_LSB];
        end else if (snoop_resp_kind == `PES_RESP_HIT) begin
            type_match = unit_mask[`PES_UM_TYPE_LSB + 1];
        end else if (snoop_resp_kind == `PES_RESP_MODIFIED_LINE_SNOOP_PIN) begin
            type_match = unit_mask[`PES_UM_TYPE_LSB + 2];
        end
    end

    assign agent_match = snoop_resp_other_agent ?
        unit_mask[`PES_UM_AGENT_LSB + 1] : unit_mask[`PES_UM_AGENT_LSB];
    assign snoop_hit = snoop_resp_valid & type_match & agent_match;

    // Fetch events are per thread; bus events never look at this
    assign thread_ok = all_threads_qualifier | (fetch_thread == owner_thread);

    always_comb begin
        inc = 1'b0;
        case (sel_if.src)
            PES_SRC_SNOOP_RESP: begin
                inc = snoop_hit;
            end
            PES_SRC_CLEAN_DRV: begin
                inc = bus_cycle_strobe & clean_snoop_pin_drive;
            end
            PES_SRC_MOD_DRV: begin
                inc = bus_cycle_strobe & modified_line_snoop_pin_drive;
            end
            PES_SRC_QUEUE_IDLE: begin
                inc = ~bus_queue_pending;
            end
            PES_SRC_STALL: begin
                inc = pes_rise(snoop_stall, state_r.stall_prev);
            end
            PES_SRC_IO_WAIT: begin
                inc = io_req_waiting;
            end
            PES_SRC_FETCH: begin
                inc = fetch_valid & thread_ok;
            end
            PES_SRC_FETCH_MISS: begin
                // Uncacheable fetches raise the pending level too
                inc = pes_rise(fetch_miss_pending, state_r.miss_prev)
                    & thread_ok;
            end
            PES_SRC_TLB_FLUSH: begin
                inc = tlb_flush & thread_ok;
            end
            PES_SRC_TLB_MISS: begin
                inc = tlb_miss & thread_ok;
            end
            default: begin
                inc = 1'b0;
            end
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        state_nxt.stall_prev = snoop_stall;
        state_nxt.miss_prev = fetch_miss_pending;
        // An event in the clear cycle survives as the first count
        if (count_clear) begin
            state_nxt.count = inc ? `PES_CNT_ONE : `PES_CNT_RST;
        end else if (inc) begin
            state_nxt.count = state_r.count + `PES_CNT_ONE;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign count = state_r.count;
    // Snooped requests held back while stall is up
    assign bus_req_grant = bus_req_valid
        & ~(snoop_stall & bus_req_needs_snoop);

    a_snoop_counts: assert property (
        @(posedge clk) disable iff (!rst_b)
        (event_num == `PES_EV_SNOOP_RESP && snoop_resp_valid
            && snoop_resp_kind <= `PES_RESP_MODIFIED_LINE_SNOOP_PIN && !count_clear
            && unit_mask[`PES_UM_TYPE_LSB + snoop_resp_kind]
            && unit_mask[`PES_UM_AGENT_LSB + snoop_resp_other_agent])
        |=> count == $past(count) + `PES_CNT_ONE
    ) else $error("snoop response not counted");

    a_snoop_filter: assert property (
        @(posedge clk) disable iff (!rst_b)
        (event_num == `PES_EV_SNOOP_RESP && snoop_resp_valid && !count_clear
            && !unit_mask[`PES_UM_TYPE_LSB + snoop_resp_kind])
        |=> $stable(count)
    ) else $error("filtered snoop response counted");

    a_bus_whole_core: assert property (
        @(posedge clk) disable iff (!rst_b)
        (event_num == `PES_EV_QUEUE_IDLE && !bus_queue_pending
            && !all_threads_qualifier && fetch_thread != owner_thread
            && !count_clear)
        |=> count == $past(count) + `PES_CNT_ONE
    ) else $error("bus event filtered by thread");

    a_clean_drive: assert property (
        @(posedge clk) disable iff (!rst_b)
        (event_num == `PES_EV_CLEAN_DRV && !count_clear)
        |=> count == $past(count)
            + ($past(bus_cycle_strobe) & $past(clean_snoop_pin_drive))
    ) else $error("clean pin drive miscounted");

    a_mod_drive: assert property (
        @(posedge clk) disable iff (!rst_b)
        (event_num == `PES_EV_MOD_DRV && !bus_cycle_strobe && !count_clear)
        |=> $stable(count)
    ) else $error("modified pin counted off bus cycle");

    a_queue_busy: assert property (
        @(posedge clk) disable iff (!rst_b)
        (event_num == `PES_EV_QUEUE_IDLE && bus_queue_pending
            && !count_clear) [*2]
        |=> $stable(count)
    ) else $error("busy queue counted as idle");

    a_stall_once: assert property (
        @(posedge clk) disable iff (!rst_b)
        (event_num == `PES_EV_STALL && !count_clear && !snoop_stall)
        ##1 (event_num == `PES_EV_STALL && !count_clear && snoop_stall) [*3]
        |=> count == $past(count, 3) + `PES_CNT_ONE
    ) else $error("stall assertion miscounted");

    a_stall_gate: assert property (
        @(posedge clk) disable iff (!rst_b)
        (snoop_stall && bus_req_needs_snoop) |-> !bus_req_grant
    ) else $error("snooped request granted during stall");

    a_io_wait: assert property (
        @(posedge clk) disable iff (!rst_b)
        (event_num == `PES_EV_IO_WAIT && io_req_waiting && !count_clear)
        |=> count == $past(count) + `PES_CNT_ONE
    ) else $error("io wait cycle not counted");

    a_fetch_all: assert property (
        @(posedge clk) disable iff (!rst_b)
        (event_num == `PES_EV_FETCH && unit_mask == `PES_UM_FETCH_ALL
            && fetch_valid && all_threads_qualifier && !count_clear)
        |=> count == $past(count) + `PES_CNT_ONE
    ) else $error("fetch not counted");

    a_miss_once: assert property (
        @(posedge clk) disable iff (!rst_b)
        (event_num == `PES_EV_FETCH && unit_mask == `PES_UM_FETCH_MISS
            && fetch_miss_pending && !count_clear) [*2]
        |=> $stable(count)
    ) else $error("outstanding miss counted twice");

    a_tlb_flush: assert property (
        @(posedge clk) disable iff (!rst_b)
        (event_num == `PES_EV_TLB && unit_mask == `PES_UM_TLB_FLUSH
            && tlb_flush && !count_clear
            && (all_threads_qualifier || fetch_thread == owner_thread))
        |=> count == $past(count) + `PES_CNT_ONE
    ) else $error("translation flush not counted");

    a_tlb_miss: assert property (
        @(posedge clk) disable iff (!rst_b)
        (event_num == `PES_EV_TLB && unit_mask == `PES_UM_TLB_MISS
            && tlb_miss && !count_clear
            && (all_threads_qualifier || fetch_thread == owner_thread))
        |=> count == $past(count) + `PES_CNT_ONE
    ) else $error("translation miss not counted");

    a_bad_select: assert property (
        @(posedge clk) disable iff (!rst_b)
        (sel_if.src == PES_SRC_NONE && !count_clear) |=> $stable(count)
    ) else $error("unimplemented selection counted");

    a_snoop_agent: assert property (
        @(posedge clk) disable iff (!rst_b)
        (event_num == `PES_EV_SNOOP_RESP && snoop_resp_valid && !count_clear
            && !unit_mask[`PES_UM_AGENT_LSB + snoop_resp_other_agent])
        |=> $stable(count)
    ) else $error("snoop from unselected agent counted");

    a_mod_counts: assert property (
        @(posedge clk) disable iff (!rst_b)
        (event_num == `PES_EV_MOD_DRV && bus_cycle_strobe
            && modified_line_snoop_pin_drive && !count_clear)
        |=> count == $past(count) + `PES_CNT_ONE
    ) else $error("modified pin drive not counted");

    a_idle_counts: assert property (
        @(posedge clk) disable iff (!rst_b)
        (event_num == `PES_EV_QUEUE_IDLE && !bus_queue_pending
            && !count_clear)
        |=> count == $past(count) + `PES_CNT_ONE
    ) else $error("idle queue cycle not counted");

    a_stall_held: assert property (
        @(posedge clk) disable iff (!rst_b)
        (event_num == `PES_EV_STALL && snoop_stall && !count_clear) [*2]
        |=> $stable(count)
    ) else $error("held stall counted again");

    a_grant_free: assert property (
        @(posedge clk) disable iff (!rst_b)
        (bus_req_valid && !(snoop_stall && bus_req_needs_snoop))
        |-> bus_req_grant
    ) else $error("allowed request not granted");

    a_io_idle: assert property (
        @(posedge clk) disable iff (!rst_b)
        (event_num == `PES_EV_IO_WAIT && !io_req_waiting && !count_clear)
        |=> $stable(count)
    ) else $error("io count without waiting request");

    a_fetch_thread: assert property (
        @(posedge clk) disable iff (!rst_b)
        (event_num == `PES_EV_FETCH && unit_mask == `PES_UM_FETCH_ALL
            && !all_threads_qualifier && fetch_thread != owner_thread
            && !count_clear)
        |=> $stable(count)
    ) else $error("fetch of other thread counted");

    a_miss_rise: assert property (
        @(posedge clk) disable iff (!rst_b)
        (event_num == `PES_EV_FETCH && unit_mask == `PES_UM_FETCH_MISS
            && !fetch_miss_pending)
        ##1 (event_num == `PES_EV_FETCH && unit_mask == `PES_UM_FETCH_MISS
            && fetch_miss_pending && all_threads_qualifier && !count_clear)
        |=> count == $past(count) + `PES_CNT_ONE
    ) else $error("new fetch miss not counted");

    a_fetch_bad_mask: assert property (
        @(posedge clk) disable iff (!rst_b)
        (event_num == `PES_EV_FETCH && unit_mask != `PES_UM_FETCH_ALL
            && unit_mask != `PES_UM_FETCH_MISS && !count_clear)
        |=> $stable(count)
    ) else $error("fetch event counted under bad mask");

    a_tlb_bad_mask: assert property (
        @(posedge clk) disable iff (!rst_b)
        (event_num == `PES_EV_TLB && unit_mask != `PES_UM_TLB_FLUSH
            && unit_mask != `PES_UM_TLB_MISS && !count_clear)
        |=> $stable(count)
    ) else $error("translation event counted under bad mask");

endmodule : pes_event_counter

// >>> testbench/pes_far_model.sv
`timescale 1ns/1ns

module pes_far_model (
    // Stimulus from the bench
    input wire logic [16:0] pat,
    input wire logic rude,
    // Bus agents
    output logic bus_cycle_strobe,
    output logic snoop_resp_valid,
    output logic [1:0] snoop_resp_kind,
    output logic snoop_resp_other_agent,
    output logic clean_snoop_pin_drive,
    output logic modified_line_snoop_pin_drive,
    output logic bus_queue_pending,
    output logic snoop_stall,
    output logic io_req_waiting,
    output logic bus_req_valid,
    output logic bus_req_needs_snoop,
    // Fetch unit
    output logic fetch_valid,
    output logic fetch_thread,
    output logic fetch_miss_pending,
    output logic tlb_flush,
    output logic tlb_miss
);
    logic needs_raw;

    assign {tlb_miss, tlb_flush, fetch_miss_pending, fetch_thread,
            fetch_valid, needs_raw, bus_req_valid, io_req_waiting,
            snoop_stall, bus_queue_pending, modified_line_snoop_pin_drive,
            clean_snoop_pin_drive, snoop_resp_other_agent, snoop_resp_kind,
            snoop_resp_valid, bus_cycle_strobe} = pat;
    // Polite agents clear the snoop need on their requests while stalled
    assign bus_req_needs_snoop = needs_raw & (rude | ~snoop_stall);
endmodule : pes_far_model

// >>> testbench/pes_event_counter_tb_top.sv
`timescale 1ns/1ns
`include "pes_map.svh"

module pes_event_counter_tb_top;
    typedef struct packed {
        logic g;
        logic [`PES_CNT_W-1:0] c;
    } pes_note_type;

    logic clk, rst_b, all_thr, owner, clr, rude, grant, inc;
    logic stall_p, miss_p, have, thr_ok;
    logic [7:0] ev, um;
    logic [16:0] pat;
    logic [`PES_CNT_W-1:0] count, exp_cnt;
    logic sv, oth, cln, mod, pend, stl, io, rv, rn, fv, ft, fm, fl, tm, bs;
    logic [1:0] kind;
    logic [15:0] tab [17] = '{16'h7733, 16'h7711, 16'h7724, 16'h7707,
        16'h7730, 16'h7A00, 16'h7BFF, 16'h7D00, 16'h7E00, 16'h7F00,
        16'h8003, 16'h8002, 16'h8001, 16'h8204, 16'h8202, 16'h8203,
        16'h7C00};
    pes_note_type q[$];
    pes_note_type nt;
    int n_fail = 0;
    int n_compared = 0;
    int seed;

    pes_far_model u_pes_far_model (.pat(pat), .rude(rude),
        .bus_cycle_strobe(bs), .snoop_resp_valid(sv),
        .snoop_resp_kind(kind), .snoop_resp_other_agent(oth),
        .clean_snoop_pin_drive(cln), .modified_line_snoop_pin_drive(mod),
        .bus_queue_pending(pend), .snoop_stall(stl), .io_req_waiting(io),
        .bus_req_valid(rv), .bus_req_needs_snoop(rn), .fetch_valid(fv),
        .fetch_thread(ft), .fetch_miss_pending(fm), .tlb_flush(fl),
        .tlb_miss(tm));

    pes_event_counter u_pes_event_counter (.clk(clk), .rst_b(rst_b),
        .event_num(ev), .unit_mask(um), .all_threads_qualifier(all_thr),
        .owner_thread(owner), .count_clear(clr), .bus_cycle_strobe(bs),
        .snoop_resp_valid(sv), .snoop_resp_kind(kind),
        .snoop_resp_other_agent(oth), .clean_snoop_pin_drive(cln),
        .modified_line_snoop_pin_drive(mod), .bus_queue_pending(pend),
        .snoop_stall(stl), .io_req_waiting(io), .bus_req_valid(rv),
        .bus_req_needs_snoop(rn), .bus_req_grant(grant), .fetch_valid(fv),
        .fetch_thread(ft), .fetch_miss_pending(fm), .tlb_flush(fl),
        .tlb_miss(tm), .count(count));

    task automatic final_report;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Driver: fresh random traffic every cycle, selection stepped by table
    initial begin
        {rst_b, all_thr, owner, clr, rude, pat, ev, um} = '0;
        {stall_p, miss_p} = 2'b00;
        exp_cnt = '0;
        repeat (20) @(posedge clk);
        #1 rst_b = 1'b1;
        seed = $urandom(97);
        for (int k = 0; k < 17 * 60; k++) begin
            @(posedge clk);
            #1;
            {ev, um} = tab[k / 60];
            pat = 17'($urandom);
            rude = 1'($urandom);
            all_thr = 1'($urandom);
            owner = 1'($urandom);
            clr = ($urandom % 16) == 0;
            #1;
            thr_ok = all_thr | (ft == owner);
            case (ev)
                8'h77: inc = sv & (kind != 2'h3) & um[kind]
                    & (oth ? um[5] : um[4]);
                8'h7A: inc = cln & bs;
                8'h7B: inc = mod & bs;
                8'h7D: inc = ~pend;
                8'h7E: inc = stl & ~stall_p;
                8'h7F: inc = io;
                8'h80: inc = thr_ok & ((um == 8'h03) ? fv
                    : (um == 8'h02) & fm & ~miss_p);
                8'h82: inc = thr_ok & ((um == 8'h04) ? fl
                    : (um == 8'h02) & tm);
                default: inc = 1'b0;
            endcase
            exp_cnt = clr ? `PES_CNT_W'(inc) : exp_cnt + `PES_CNT_W'(inc);
            stall_p = stl;
            miss_p = fm;
            q.push_back('{g: rv & ~(stl & rn), c: exp_cnt});
        end
        repeat (3) @(posedge clk);
        final_report();
    end

    // Monitor: grant checked in its own cycle, count one edge later
    initial begin
        have = 1'b0;
        forever begin
            @(posedge clk);
            #1;
            if (have) begin
                n_compared++;
                if (count !== nt.c) begin
                    n_fail++;
                    $display("unexpected count at %0t: got %h exp %h",
                        $time, count, nt.c);
                end
            end
            #2;
            if (q.size() > 0) begin
                nt = q.pop_front();
                have = 1'b1;
                n_compared++;
                if (grant !== nt.g) begin
                    n_fail++;
                    $display("unexpected grant at %0t: got %h exp %h",
                        $time, grant, nt.g);
                end
            end
        end
    end

    // Hang guard
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        final_report();
    end
endmodule : pes_event_counter_tb_top
